// ===== rtl/tcc_capture_compare.v
// Purpose: input capture filter/edge/capture plus two compare channels
// Assumes: counter unit supplies count, direction, TOP/BOTTOM, timer tick
// Notes:   control bits are plain ports; no bus in this block
// Operation
// [R1] Qualifying edge copies counter into capture register and sets flag same cycle.
// [R2] Software driving the capture pin's port causes captures like external edges.
// [R3] Filter output changes only after four equal consecutive input samples.
// [R4] Filter active only while its enable bit is set, bypassed otherwise.
// [R5] Filter adds exactly four system clock cycles of capture latency.
// [R6] Filter samples on undivided system clock, ignoring prescaler.
// [R7] Every capture overwrites capture register regardless of pending reads.
// [R8] Software should read capture register early in its handler.
// [R9] Software should avoid input capture while TOP is being changed.
// [R10] Duty measurement: switch edge after read, then clear flag by writing one.
// [R11] Frequency-only measurement with handler need not clear flag manually.
// [R12] Each compare unit matches full 16-bit counter against its register.
// [R13] Compare flag sets one timer clock after the match.
// [R14] Set compare flag with enable requests compare interrupt.
// [R15] Compare flag clears on vector execution or writing one.
// [R16] Capture flag clears on vector execution or writing one.
// [R17] Compare output follows match, waveform mode and compare-output mode.
// [R18] TOP and BOTTOM strobes handle extreme values in waveform modes.
// [R19] Unit A register can serve as counter TOP value.
// [R20] PWM modes write compare values into a buffer.
// [R21] Normal and clear-on-match modes write compare register directly.
// [R22] Buffer moves to active register only at TOP or BOTTOM.
// [R23] Edge detector compares filtered sample with previous, selected polarity only.
`timescale 1ns/1ps
`include "tcc_consts.vh"
module tcc_capture_compare (
  input  wire        clk,                     // System clock, 100 MHz
  input  wire        sys_rst,                 // Sync reset, active high
  input  wire        ce,                      // Clock enable, freezes all state
  input  wire        capture_event_pin,       // External capture input, synchronous
  input  wire        port_drive_en,           // Port logic drives capture pin
  input  wire        port_drive_val,          // Level driven by port logic
  input  wire        capture_filter_enable,   // Noise filter enable
  input  wire        capture_edge_rising,     // 1 rising edge, 0 falling edge
  input  wire        capture_flag_clr,        // Write-one clear of capture flag
  input  wire        capture_vec_ack,         // Capture interrupt executed
  input  wire        capture_irq_enable,      // Capture interrupt enable
  input  wire        tick,                    // Timer clock cycle strobe
  input  wire [15:0] counter_value,           // Counter
  input  wire        top_hit,                 // Counter at TOP
  input  wire        bottom_hit,              // Counter at BOTTOM
  input  wire        count_up,                // Counter direction
  input  wire [3:0]  waveform_mode_field,     // Waveform mode
  input  wire [1:0]  compare_output_mode_a,   // Unit A output mode field
  input  wire [1:0]  compare_output_mode_b,   // Unit B output mode field
  input  wire        compare_wr_a,            // Unit A register write strobe
  input  wire        compare_wr_b,            // Unit B register write strobe
  input  wire [15:0] compare_wr_data,         // Compare write data
  input  wire        compare_flag_clr_a,      // Write-one clear, unit A flag
  input  wire        compare_flag_clr_b,      // Write-one clear, unit B flag
  input  wire        compare_vec_ack_a,       // Unit A interrupt executed
  input  wire        compare_vec_ack_b,       // Unit B interrupt executed
  input  wire        compare_irq_enable_a,    // Unit A interrupt enable
  input  wire        compare_irq_enable_b,    // Unit B interrupt enable
  output reg  [15:0] capture_value_register,  // Captured counter value
  output reg         capture_flag,            // Capture flag
  output wire        capture_irq,             // Capture interrupt request
  output wire [15:0] compare_value_a,         // Unit A active compare value
  output wire [15:0] compare_value_b,         // Unit B active compare value
  output wire [15:0] compare_buffer_a,        // Unit A buffer readback
  output wire [15:0] compare_buffer_b,        // Unit B buffer readback
  output wire        match_a,                 // Unit A comparator match
  output wire        match_b,                 // Unit B comparator match
  output wire        compare_flag_a,          // Unit A compare flag
  output wire        compare_flag_b,          // Unit B compare flag
  output wire        compare_irq_a,           // Unit A interrupt request
  output wire        compare_irq_b,           // Unit B interrupt request
  output wire        compare_out_a,           // Unit A waveform output
  output wire        compare_out_b,           // Unit B waveform output
  output wire        top_from_unit_a,         // Counter should use unit A as TOP
  output wire [15:0] top_value_a              // TOP value offered by unit A
);
  reg  [2:0] filt_run_q;
  reg        filt_last_q;
  reg        filt_out_q;
  reg        edge_prev_q;
  wire       pin_level;
  wire       edge_src;
  wire       edge_hit;
  wire       buffered;
  wire       load_at_bottom;
  wire       pwm_mode;
  wire       dual_slope;

  // Port override lets software fire a capture on the same path
  assign pin_level = port_drive_en ? port_drive_val : capture_event_pin; // [R2]

  // Filter needs four equal samples; bypass feeds the raw level
  assign edge_src = capture_filter_enable ? filt_out_q : pin_level; // [R4]

  assign edge_hit = capture_edge_rising ? (edge_src & ~edge_prev_q)
                                        : (~edge_src & edge_prev_q); // [R23]

  assign capture_irq = capture_flag & capture_irq_enable;

  // Plain filter counts samples equal to the last one; runs every clk, not on tick
  always @(posedge clk) begin // [R6]
    if (sys_rst) begin
      filt_run_q  <= `TCC_FILT_ZERO;
      filt_last_q <= 1'b0;
      filt_out_q  <= 1'b0;
      edge_prev_q <= 1'b0;
    end else if (ce) begin
      filt_last_q <= pin_level;
      if (pin_level != filt_last_q)
        filt_run_q <= `TCC_FILT_ONE;
      else if (filt_run_q != `TCC_FILT_LEN)
        filt_run_q <= filt_run_q + `TCC_FILT_ONE;
      if (pin_level == filt_last_q && filt_run_q == `TCC_FILT_LEN - `TCC_FILT_ONE)
        filt_out_q <= pin_level; // [R3] [R5]
      edge_prev_q <= edge_src;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      capture_value_register <= `TCC_ZERO16;
      capture_flag           <= 1'b0;
    end else if (ce) begin
      if (edge_hit)
        capture_value_register <= counter_value; // [R1] [R7]
      // Fresh capture beats a simultaneous clear
      if (edge_hit)
        capture_flag <= 1'b1; // [R1]
      else if (capture_flag_clr || capture_vec_ack)
        capture_flag <= 1'b0; // [R16]
    end
  end

  // Normal and clear-on-match modes are unbuffered; all others are PWM
  assign buffered = !(waveform_mode_field == `TCC_WGM_NORMAL ||
                      waveform_mode_field == `TCC_WGM_CTC_A ||
                      waveform_mode_field == `TCC_WGM_CTC_I); // [R20] [R21]
  assign pwm_mode = buffered;
  // Fast PWM reloads at TOP; dual-slope correct modes at BOTTOM (8,9) or TOP
  assign dual_slope = buffered &&
                      !((waveform_mode_field >= `TCC_WGM_FAST_LO && waveform_mode_field <= `TCC_WGM_FAST_HI) ||
                        waveform_mode_field == `TCC_WGM_FAST_I || waveform_mode_field == `TCC_WGM_FAST_A);
  assign load_at_bottom = waveform_mode_field == `TCC_WGM_PC_I || waveform_mode_field == `TCC_WGM_PC_A; // [R22]

  assign top_from_unit_a = waveform_mode_field == `TCC_WGM_CTC_A ||
                           waveform_mode_field == `TCC_WGM_TOPA_1 ||
                           waveform_mode_field == `TCC_WGM_TOPA_2 ||
                           waveform_mode_field == `TCC_WGM_TOPA_3; // [R19]
  assign top_value_a = compare_value_a; // [R19]

  tcc_compare_unit u_cmp_a (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .ce             (ce),
    .tick           (tick),
    .counter_value  (counter_value),
    .top_hit        (top_hit),
    .bottom_hit     (bottom_hit),
    .buffered       (buffered),
    .load_at_bottom (load_at_bottom),
    .pwm_mode       (pwm_mode),
    .dual_slope     (dual_slope),
    .count_up       (count_up),
    .com_mode       (compare_output_mode_a),
    .wr_en          (compare_wr_a),
    .wr_data        (compare_wr_data),
    .flag_clr       (compare_flag_clr_a),
    .vec_ack        (compare_vec_ack_a),
    .irq_enable     (compare_irq_enable_a),
    .active_q       (compare_value_a),
    .buffer_q       (compare_buffer_a),
    .match          (match_a),
    .flag_q         (compare_flag_a),
    .irq            (compare_irq_a),
    .pin_q          (compare_out_a)
  );

  tcc_compare_unit u_cmp_b (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .ce             (ce),
    .tick           (tick),
    .counter_value  (counter_value),
    .top_hit        (top_hit),
    .bottom_hit     (bottom_hit),
    .buffered       (buffered),
    .load_at_bottom (load_at_bottom),
    .pwm_mode       (pwm_mode),
    .dual_slope     (dual_slope),
    .count_up       (count_up),
    .com_mode       (compare_output_mode_b),
    .wr_en          (compare_wr_b),
    .wr_data        (compare_wr_data),
    .flag_clr       (compare_flag_clr_b),
    .vec_ack        (compare_vec_ack_b),
    .irq_enable     (compare_irq_enable_b),
    .active_q       (compare_value_b),
    .buffer_q       (compare_buffer_b),
    .match          (match_b),
    .flag_q         (compare_flag_b),
    .irq            (compare_irq_b),
    .pin_q          (compare_out_b)
  );
endmodule // tcc_capture_compare

// ===== inc/tcc_consts.vh
// Purpose: constants for the 16-bit timer capture/compare block
// Assumes: 100 MHz system clock
// Notes:   mode codes follow the 4-bit waveform mode field
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH
`define TCC_CNT_W        16
`define TCC_ZERO16       16'h0000
`define TCC_FILT_LEN     3'h4
`define TCC_FILT_ONE     3'h1
`define TCC_FILT_ZERO    3'h0
`define TCC_WGM_NORMAL   4'h0
`define TCC_WGM_CTC_A    4'h4
`define TCC_WGM_CTC_I    4'hC
`define TCC_WGM_PC_I     4'h8
`define TCC_WGM_PC_A     4'h9
`define TCC_WGM_PFC_I    4'h8
`define TCC_WGM_TOPA_1   4'h9
`define TCC_WGM_TOPA_2   4'hB
`define TCC_WGM_TOPA_3   4'hF
`define TCC_WGM_FAST_LO  4'h5
`define TCC_WGM_FAST_HI  4'h7
`define TCC_WGM_FAST_I   4'hE
`define TCC_WGM_FAST_A   4'hF
`define TCC_COM_OFF      2'h0
`define TCC_COM_TOGGLE   2'h1
`define TCC_COM_CLEAR    2'h2
`define TCC_COM_SET      2'h3
`endif

// ===== rtl/tcc_compare_unit.v
// Purpose: one output compare channel: buffer, comparator, flag, waveform pin
// Assumes: counter, TOP/BOTTOM strobes and timer tick come from the counter unit
// Notes:   tick marks the timer clock cycle
`timescale 1ns/1ps
`include "tcc_consts.vh"
module tcc_compare_unit (
  input  wire        clk,           // System clock
  input  wire        sys_rst,       // Sync reset, active high
  input  wire        ce,            // Clock enable
  input  wire        tick,          // Timer clock cycle strobe
  input  wire [15:0] counter_value, // Counter
  input  wire        top_hit,       // Counter at TOP
  input  wire        bottom_hit,    // Counter at BOTTOM
  input  wire        buffered,      // PWM mode active
  input  wire        load_at_bottom,// Buffer loads at BOTTOM, else TOP
  input  wire        pwm_mode,      // Pin uses PWM set/clear rules
  input  wire        dual_slope,    // Phase-correct style pin handling
  input  wire        count_up,      // Counter direction
  input  wire [1:0]  com_mode,      // Compare output mode field
  input  wire        wr_en,         // Compare register write strobe
  input  wire [15:0] wr_data,       // Compare register write data
  input  wire        flag_clr,      // Software write-one clear
  input  wire        vec_ack,       // Interrupt vector executed
  input  wire        irq_enable,    // Compare interrupt enable
  output reg  [15:0] active_q,      // Active compare value
  output reg  [15:0] buffer_q,      // Buffer value
  output wire        match,         // Comparator equality
  output reg         flag_q,        // Compare flag
  output wire        irq,           // Interrupt request
  output reg         pin_q          // Waveform output
);
  reg match_q;
  reg pin_d;

  assign match = (counter_value == active_q); // [R12]
  assign irq   = flag_q & irq_enable;         // [R14]

  always @* begin // [R17] [R18]
    pin_d = pin_q;
    if (!pwm_mode) begin
      if (match && tick) begin
        case (com_mode)
          `TCC_COM_TOGGLE: pin_d = ~pin_q;
          `TCC_COM_CLEAR:  pin_d = 1'b0;
          `TCC_COM_SET:    pin_d = 1'b1;
          default:         pin_d = pin_q;
        endcase
      end
    end else if (tick && com_mode[1]) begin
      if (dual_slope) begin
        if (match)
          pin_d = com_mode[0] ^ count_up ? 1'b0 : 1'b1;
      end else if (match)
        pin_d = com_mode[0];
      else if (bottom_hit)
        pin_d = ~com_mode[0];
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      active_q <= `TCC_ZERO16;
      buffer_q <= `TCC_ZERO16;
      match_q  <= 1'b0;
      flag_q   <= 1'b0;
      pin_q    <= 1'b0;
    end else if (ce) begin
      if (wr_en)
        buffer_q <= wr_data; // [R20]
      if (!buffered) begin
        if (wr_en)
          active_q <= wr_data; // [R21]
      end else if (tick && (load_at_bottom ? bottom_hit : top_hit))
        active_q <= buffer_q; // [R22]
      if (tick)
        match_q <= match;
      pin_q <= pin_d;
      // Set wins over either clear so a late match is never lost
      if (tick && match_q)
        flag_q <= 1'b1; // [R13]
      else if (flag_clr || vec_ack)
        flag_q <= 1'b0; // [R15]
    end
  end
endmodule // tcc_compare_unit

// ===== verification/tcc_evt_src.sv
// Purpose: far-side event source driving the capture line
// Assumes: called just after a falling clock edge
// Notes:   line is always driven, never released
`timescale 1ns/1ps
module tcc_evt_src (
  input  wire clk, // System clock
  output reg  pin  // Event line
);
  initial pin = 1'h0;
  task drive(input reg v);
    pin = v;
  endtask
  // Short pulse, too brief for a filter
  task glitch(input integer n);
    begin
      pin = ~pin;
      repeat (n) @(negedge clk);
      pin = ~pin;
    end
  endtask
endmodule // tcc_evt_src

// ===== verification/tcc_cc_assertions.sv
// Purpose: port-level checks of capture and compare behaviour
// Assumes: single clock domain, sync reset
// Notes:   port bundles grouped to keep the file short
`timescale 1ns/1ps
`include "tcc_consts.vh"
module tcc_cc_checker (
  input wire        clk, sys_rst, ce, capture_event_pin, port_drive_en, port_drive_val, tick, top_hit,
  input wire        capture_filter_enable, capture_edge_rising, capture_flag_clr, capture_vec_ack,
  input wire        compare_wr_a, compare_flag_clr_a, compare_vec_ack_a, compare_flag_clr_b, compare_vec_ack_b,
  input wire [15:0] counter_value, compare_wr_data, capture_value_register, top_value_a,
  input wire [15:0] compare_value_a, compare_value_b, compare_buffer_a,
  input wire [3:0]  waveform_mode_field,
  input wire [1:0]  compare_output_mode_a,
  input wire        capture_flag, match_a, match_b, compare_flag_a, compare_flag_b, compare_out_a, top_from_unit_a
);
  wire       lvl = port_drive_en ? port_drive_val : capture_event_pin;
  reg        lvl_q;
  reg        byp_q;
  reg  [2:0] lo_q;
  // Low-run count needs the filter on throughout
  always @(posedge clk) begin
    lvl_q <= lvl;
    byp_q <= ce & ~capture_filter_enable & ~sys_rst;
    lo_q  <= (sys_rst | lvl | ~capture_filter_enable) ? 3'h0 : ((lo_q == 3'h4) ? lo_q : lo_q + 3'h1);
  end
  wire byp = byp_q & ce & ~capture_filter_enable;
  wire hit = capture_edge_rising ? (lvl & ~lvl_q) : (~lvl & lvl_q);
  wire fup = lvl & ce & capture_filter_enable & capture_edge_rising & ~capture_flag_clr & ~capture_vec_ack;
  wire [3:0] m = waveform_mode_field;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_CAP_VALUE: assert property (byp && hit |=> capture_flag && capture_value_register == $past(counter_value))
    else $error("capture value or flag wrong");
  AST_CAP_EDGE: assert property (byp && lvl != lvl_q && !hit |=> $stable(capture_value_register))
    else $error("capture on unselected edge");
  AST_FILT_DELAY: assert property (lo_q == 3'h4 ##0 fup [*5] |=> capture_flag)
    else $error("filtered capture late");
  AST_CAP_CLEAR: assert property (capture_flag && (capture_flag_clr || capture_vec_ack) && byp && lvl == lvl_q
    |=> !capture_flag) else $error("capture flag not cleared");
  AST_MATCH: assert property (match_a == (counter_value == compare_value_a) && match_b == (counter_value == compare_value_b))
    else $error("comparator mismatch");
  AST_FLAG_LATE: assert property ($rose(compare_flag_a) && $past(tick) && $past(tick, 2) |-> $past(match_a, 2))
    else $error("compare flag not one tick after match");
  AST_FLAG_SET: assert property (ce && tick && match_b ##1 (ce && tick && !compare_flag_clr_b && !compare_vec_ack_b)
    |=> compare_flag_b) else $error("compare flag missed");
  AST_CMP_CLEAR: assert property (compare_flag_a && (compare_flag_clr_a || compare_vec_ack_a) && $past(tick) && !$past(match_a)
    |=> !compare_flag_a) else $error("compare flag not cleared");
  AST_DIRECT_WR: assert property (ce && compare_wr_a && (m == `TCC_WGM_NORMAL || m == `TCC_WGM_CTC_A || m == `TCC_WGM_CTC_I)
    |=> compare_value_a == $past(compare_wr_data)) else $error("direct write lost");
  AST_RELOAD: assert property (ce && tick && top_hit && m == `TCC_WGM_FAST_A && !compare_wr_a
    |=> compare_value_a == $past(compare_buffer_a)) else $error("buffer not loaded at top");
  AST_TOP_A: assert property (top_value_a == compare_value_a && top_from_unit_a == (m == `TCC_WGM_CTC_A
    || m == `TCC_WGM_TOPA_1 || m == `TCC_WGM_TOPA_2 || m == `TCC_WGM_TOPA_3)) else $error("top source wrong");
  AST_PIN: assert property (ce && tick && match_a && m == `TCC_WGM_CTC_A && compare_output_mode_a == `TCC_COM_TOGGLE
    |=> compare_out_a != $past(compare_out_a)) else $error("output not toggled");
  cover property (byp && hit);
  cover property (lo_q == 3'h4 ##0 fup [*5]);
  cover property ($rose(compare_flag_a));
endmodule // tcc_cc_checker
bind tcc_capture_compare tcc_cc_checker chk_i (.*);

// ===== verification/tb.sv
// Purpose: self-checking bench for the capture/compare block
// Assumes: inputs change on the falling edge
// Notes:   counter is a plain up-count made here
`timescale 1ns/1ps
module tb;
  reg clk, sys_rst, ce, tick, count_up, top_hit, bottom_hit, port_drive_en, port_drive_val;
  reg capture_filter_enable, capture_edge_rising, capture_flag_clr, capture_vec_ack, capture_irq_enable;
  reg compare_wr_a, compare_wr_b, compare_flag_clr_a, compare_flag_clr_b, compare_vec_ack_a, compare_vec_ack_b;
  reg compare_irq_enable_a, compare_irq_enable_b;
  reg [3:0] waveform_mode_field;
  reg [1:0] compare_output_mode_a, compare_output_mode_b;
  reg [15:0] counter_value, compare_wr_data, e;
  wire [15:0] capture_value_register, compare_value_a, compare_value_b, compare_buffer_a, compare_buffer_b, top_value_a;
  wire capture_event_pin, capture_flag, capture_irq, match_a, match_b, compare_flag_a, compare_flag_b;
  wire compare_irq_a, compare_irq_b, compare_out_a, compare_out_b, top_from_unit_a;
  reg [36:0] rows [0:6];
  integer miscompares, n_compared, cyc, i;
  tcc_capture_compare dut (.*);
  tcc_evt_src src (.clk(clk), .pin(capture_event_pin));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) counter_value <= sys_rst ? 16'h0000 : counter_value + 16'h0001;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  end
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task cap(input reg v, input integer n, input reg hit, input reg viaport);
    begin
      e = capture_value_register;
      if (viaport) port_drive_val = v;
      else src.drive(v);
      repeat (n - 1) @(negedge clk);
      if (n > 1) chk(capture_flag, 16'h0000);
      @(posedge clk) if (hit) e = counter_value;
      @(negedge clk) chk(capture_value_register, e);
      if (hit) chk({capture_flag, capture_irq}, 16'h0003);
    end
  endtask
  initial begin
    {ce, tick, count_up, sys_rst, capture_edge_rising} = 5'h1F;
    {top_hit, bottom_hit, port_drive_en, port_drive_val, capture_filter_enable, capture_flag_clr, capture_vec_ack} = 7'h00;
    {capture_irq_enable, compare_wr_a, compare_wr_b, compare_flag_clr_a, compare_flag_clr_b} = 5'h00;
    {compare_vec_ack_a, compare_vec_ack_b, compare_irq_enable_a, compare_irq_enable_b} = 4'h0;
    {waveform_mode_field, compare_output_mode_a, compare_output_mode_b} = 8'h02;
    {compare_wr_data, miscompares, n_compared, cyc} = 0;
    rows[0] = {4'h0, 16'h1234, 16'h1234, 1'h0};
    rows[1] = {4'h4, 16'h00FF, 16'h00FF, 1'h1};
    rows[2] = {4'hC, 16'h0ABC, 16'h0ABC, 1'h0};
    rows[3] = {4'hE, 16'h5555, 16'h0ABC, 1'h0};
    rows[4] = {4'h8, 16'h7777, 16'h0ABC, 1'h0};
    rows[5] = {4'h9, 16'h0100, 16'h0ABC, 1'h1};
    rows[6] = {4'hF, 16'h2222, 16'h0ABC, 1'h1};
    repeat (10) @(negedge clk);
    sys_rst = 1'h0;
    chk({capture_flag, compare_flag_a, compare_flag_b, compare_out_a, compare_out_b}, 16'h0000);
    chk(capture_value_register | compare_value_a, 16'h0000);
    for (i = 0; i < 7; i = i + 1) begin
      {waveform_mode_field, compare_wr_data} = rows[i][36:17];
      {compare_wr_a, compare_wr_b} = 2'h3;
      @(negedge clk) {compare_wr_a, compare_wr_b} = 2'h0;
      chk(compare_value_a, rows[i][16:1]);
      chk(compare_value_b, rows[i][16:1]);
      chk(compare_buffer_a, rows[i][32:17]);
      chk(top_from_unit_a, rows[i][0]);
    end
    {top_hit, bottom_hit} = 2'h3;
    @(negedge clk) {top_hit, bottom_hit} = 2'h0;
    chk(compare_value_a, 16'h2222);
    chk(compare_out_b, 16'h0001);
    chk(top_value_a, 16'h2222);
    {waveform_mode_field, compare_output_mode_a, compare_irq_enable_a} = 7'h23;
    compare_wr_data = counter_value + 16'h0010;
    {compare_wr_a, compare_wr_b, compare_flag_clr_a, compare_flag_clr_b} = 4'hF;
    @(negedge clk) {compare_wr_a, compare_wr_b, compare_flag_clr_a, compare_flag_clr_b} = 4'h0;
    // Pin level before the match, to see the toggle it causes
    e = {15'h0000, compare_out_a};
    for (i = 0; i < 40 && match_a !== 1'h1; i = i + 1) @(negedge clk);
    chk(match_b, 16'h0001);
    chk(compare_flag_a, 16'h0000);
    chk({compare_out_a, compare_out_b}, {14'h0000, ~e[0], 1'h0});
    @(negedge clk) chk({compare_flag_a, compare_flag_b, compare_irq_a, compare_irq_b}, 16'h000E);
    chk(compare_out_a, {15'h0000, ~e[0]});
    {compare_flag_clr_a, compare_vec_ack_b} = 2'h3;
    @(negedge clk) {compare_flag_clr_a, compare_vec_ack_b} = 2'h0;
    chk({compare_flag_a, compare_flag_b}, 16'h0000);
    capture_irq_enable = 1'h1; // TOP held still while capturing
    cap(1'h1, 1, 1'h1, 1'h0);
    cap(1'h0, 1, 1'h0, 1'h0);
    cap(1'h1, 1, 1'h1, 1'h0);
    // Duty-cycle use: flip the edge after reading, then clear
    capture_edge_rising = 1'h0;
    capture_flag_clr = 1'h1;
    @(negedge clk) capture_flag_clr = 1'h0;
    chk(capture_flag, 16'h0000);
    cap(1'h0, 1, 1'h1, 1'h0);
    capture_vec_ack = 1'h1;
    @(negedge clk) capture_vec_ack = 1'h0;
    chk(capture_flag, 16'h0000);
    {capture_edge_rising, port_drive_en} = 2'h3;
    @(negedge clk) cap(1'h1, 1, 1'h1, 1'h1);
    port_drive_val = 1'h0;
    @(negedge clk) {port_drive_en, capture_filter_enable, capture_flag_clr} = 3'h3;
    repeat (6) @(negedge clk) capture_flag_clr = 1'h0;
    // Timer tick held off: filter must still run
    tick = 1'h0;
    cap(1'h1, 5, 1'h1, 1'h0);
    {tick, capture_flag_clr} = 2'h3;
    src.drive(1'h0);
    repeat (6) @(negedge clk) capture_flag_clr = 1'h0;
    src.glitch(3);
    repeat (8) @(negedge clk);
    chk(capture_flag, 16'h0000);
    // Frozen enable holds a raw edge off until it returns
    {ce, capture_filter_enable} = 2'h0;
    e = capture_value_register;
    src.drive(1'h1);
    repeat (2) @(negedge clk);
    chk(capture_value_register, e);
    chk(capture_flag, 16'h0000);
    ce = 1'h1;
    @(posedge clk) e = counter_value;
    @(negedge clk) chk(capture_value_register, e);
    // Mid-run reset with the line low: no false edge after it
    sys_rst = 1'h1;
    src.drive(1'h0);
    @(negedge clk) sys_rst = 1'h0;
    chk({capture_flag, compare_flag_a, compare_flag_b, compare_out_a, compare_out_b}, 16'h0000);
    chk(capture_value_register | compare_value_a | compare_buffer_b, 16'h0000);
    repeat (2) @(negedge clk);
    chk(capture_flag, 16'h0000);
    tally_and_finish;
  end
endmodule // tb
